/* File: design/lip_defs.svh */
// Constants of the legacy byte-wide port adapter: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef LIP_DEFS_SVH
`define LIP_DEFS_SVH

// Byte offsets of the sixteen one-byte slots
`define LIP_OFF_PORT_B_DATA 13'h0000
`define LIP_OFF_PORT_A_DATA 13'h0200
`define LIP_OFF_PORT_B_DIR 13'h0400
`define LIP_OFF_PORT_A_DIR 13'h0600
`define LIP_OFF_T1_CNT_LO 13'h0800
`define LIP_OFF_T1_CNT_HI 13'h0a00
`define LIP_OFF_T1_RLD_LO 13'h0c00
`define LIP_OFF_T1_RLD_HI 13'h0e00
`define LIP_OFF_T2_CNT_LO 13'h1000
`define LIP_OFF_T2_CNT_HI 13'h1200
`define LIP_OFF_SHIFTER 13'h1400
`define LIP_OFF_AUX_SETUP 13'h1600
`define LIP_OFF_HS_SETUP 13'h1800
`define LIP_OFF_IRQ_FLAGS 13'h1a00
`define LIP_OFF_IRQ_EN 13'h1c00
`define LIP_OFF_PORT_A_ALIAS 13'h1e00

// Slot spacing: slot index starts at this bit
`define LIP_SLOT_SHIFT 9

// Port A field positions
`define LIP_PA_CLK_SEL_BIT 3
`define LIP_PA_WAIT_A_BIT 4
`define LIP_PA_WAIT_B_BIT 6
`define LIP_PA_WAIT_IN_BIT 7

// Bits that read their pin when input; others read zero, except port A bit 7, which shows the gated wait
`define LIP_PA_PIN_MASK 8'h58
`define LIP_PB_PIN_MASK 8'h00

// Reset values
`define LIP_DATA_RST 8'h00
`define LIP_DIR_RST 8'h00

// Internal adapter clock period (us) and system clock period (ns)
`define LIP_INT_CLK_PERIOD_US 1.27655
`define LIP_MCLK_PERIOD_NS 8.0

`endif

/* File: design/lip_pkg.sv */
// Types shared by the legacy byte-wide port adapter.
// Assumes nothing beyond a SystemVerilog compiler.
package lip_pkg;

  // Bus access sequencer states, one-hot
  typedef enum logic [2:0] {
    LIP_ST_IDLE = 3'b001,
    LIP_ST_WAIT = 3'b010,
    LIP_ST_ACK = 3'b100
  } lip_state_t;

  // Index of a one-byte register slot
  typedef logic [3:0] lip_slot_t;

  // One byte of register or port data
  typedef logic [7:0] lip_byte_t;

endpackage

/* File: design/lip_tick.sv */
// One-shot delay: a done pulse a fixed number of cycles after start.
// Assumes start comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module lip_tick #(
  parameter int CYC = 160
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic done_o
);
  import lip_pkg::*;

  logic [15:0] cnt_q; // Cycles left in the current delay
  logic done_q; // Pulse at the end of the delay

  // Load on start, count down to zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_i)
      begin
        cnt_q <= 16'(CYC);
      end
      else if (cnt_q != 16'h0000)
      begin
        cnt_q <= cnt_q - 16'h0001;
      end
      done_q <= (!start_i) && (cnt_q == 16'h0001);
    end
  end

  assign done_o = done_q;
endmodule // lip_tick
`default_nettype wire

/* File: design/lip_port.sv */
// Pin side of one 8-bit port: synchronisers and the read-back value.
// Assumes pin inputs arrive asynchronously to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module lip_port #(
  parameter logic [7:0] PIN_MASK = 8'h00
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] dir_i,
  output logic [7:0] rd_o
);
  import lip_pkg::*;

  lip_byte_t meta_q; // First synchroniser stage, read by sync_q only
  lip_byte_t sync_q; // Second synchroniser stage

  // Two-flop synchroniser for the pins
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else if (ce_i)
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // Outputs read their latch; unused inputs read zero
  assign rd_o = (dir_i & data_i) | (~dir_i & sync_q & PIN_MASK);
endmodule // lip_port
`default_nettype wire

/* File: design/lip_top.sv */
// Legacy byte-wide port adapter: sixteen-slot register map behind classic
// Wishbone, two 8-bit bidirectional ports, clock select and wait gating.
// Assumes a single-cycle classic Wishbone master on mclk_i, asynchronous
// pins and serial wait/request lines, and a clock mux outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "lip_defs.svh"
module lip_top #(
  // Cycles of mclk_i in one internal adapter period, rounded up
  parameter int TICK_CYC = int'($ceil(`LIP_INT_CLK_PERIOD_US * 1000.0 / `LIP_MCLK_PERIOD_NS))
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [12:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port A pins
  input wire logic [7:0] port_a_in_i,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_a_oe_o,
  // Port B pins
  input wire logic [7:0] port_b_in_i,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_b_oe_o,
  // Serial controller side
  input wire logic chan_a_wait_request_n_i,
  input wire logic chan_b_wait_request_n_i,
  output logic chan_a_rxtx_clock_pin_ext_o,
  output logic chan_a_wait_gate_o,
  output logic chan_b_wait_gate_o
);
  import lip_pkg::*;

  // Slot index of a byte address
  function automatic lip_slot_t slot_of(input logic [12:0] adr);
    slot_of = adr[12:`LIP_SLOT_SHIFT];
  endfunction

  // Address lies on a slot boundary
  function automatic logic on_slot(input logic [12:0] adr);
    on_slot = (adr[`LIP_SLOT_SHIFT-1:0] == 9'h000);
  endfunction

  // Address selects a given register offset exactly
  function automatic logic hits(input logic [12:0] adr, input logic [12:0] off);
    hits = on_slot(adr) && (slot_of(adr) == slot_of(off));
  endfunction

  // Bit is driven high: direction out and latch one
  function automatic logic drives_one(input lip_byte_t data, input lip_byte_t dir,
                                      input int pos);
    drives_one = dir[pos] & data[pos];
  endfunction

  // Register state
  lip_state_t state_q; // Bus access sequencer
  lip_state_t state_d; // Next sequencer state
  lip_byte_t pa_data_q; // Port A output latch
  lip_byte_t pb_data_q; // Port B output latch
  lip_byte_t pa_dir_q; // Port A direction, one drives
  lip_byte_t pb_dir_q; // Port B direction, one drives
  logic ack_q; // Wishbone acknowledge
  logic [31:0] rdat_q; // Wishbone read data
  logic clk_sel_q; // Serial clock source select
  logic gate_a_q; // Channel A wait gate
  logic gate_b_q; // Channel B wait gate

  // Wait/request synchronisers
  logic wra_meta_q; // First stage, channel A
  logic wra_q; // Synchronised channel A wait, low active
  logic wrb_meta_q; // First stage, channel B
  logic wrb_q; // Synchronised channel B wait, low active

  // Combinational helpers
  logic req; // A request is present on the bus
  logic tick_start; // Starts the internal period delay
  logic tick_done; // Internal period has elapsed
  logic commit; // Access completes this edge
  logic wr_en; // Write to the low byte lane
  logic wait_n; // Gated wait/request, low active
  lip_byte_t pa_rd; // Port A read-back from pin logic
  lip_byte_t pb_rd; // Port B read-back from pin logic
  lip_byte_t pa_view; // Port A read-back with bit 7 patched
  lip_byte_t rd_byte; // Selected register byte

  assign req = wb_cyc_i && wb_stb_i;
  assign tick_start = (state_q == LIP_ST_IDLE) && req;
  assign commit = (state_q == LIP_ST_WAIT) && tick_done;
  // Writes land at the edge where the master samples ack, while it still holds the request
  assign wr_en = (state_q == LIP_ST_ACK) && req && wb_we_i && wb_sel_i[0];

  // Internal period delay that paces every access
  lip_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(tick_start),
    .done_o(tick_done)
  );

  // Port A pin logic and read-back
  lip_port #(
    .PIN_MASK(`LIP_PA_PIN_MASK)
  ) u_port_a (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(port_a_in_i),
    .data_i(pa_data_q),
    .dir_i(pa_dir_q),
    .rd_o(pa_rd)
  );

  // Port B pin logic and read-back, every bit unused
  lip_port #(
    .PIN_MASK(`LIP_PB_PIN_MASK)
  ) u_port_b (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(port_b_in_i),
    .data_i(pb_data_q),
    .dir_i(pb_dir_q),
    .rd_o(pb_rd)
  );

  // Synchronise the serial controller wait/request lines
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wra_meta_q <= 1'b1;
      wra_q <= 1'b1;
      wrb_meta_q <= 1'b1;
      wrb_q <= 1'b1;
    end
    else if (ce_i)
    begin
      wra_meta_q <= chan_a_wait_request_n_i;
      wra_q <= wra_meta_q;
      wrb_meta_q <= chan_b_wait_request_n_i;
      wrb_q <= wrb_meta_q;
    end
  end

  // Disabled channels read inactive high; enabled ones pass through
  assign wait_n = (gate_a_q ? wra_q : 1'b1) & (gate_b_q ? wrb_q : 1'b1);

  // Bit 7 shows the gated wait state while it is an input
  always_comb
  begin
    pa_view = pa_rd;
    if (!pa_dir_q[`LIP_PA_WAIT_IN_BIT])
    begin
      pa_view[`LIP_PA_WAIT_IN_BIT] = wait_n;
    end
  end

  // Read mux over the sixteen slots
  always_comb
  begin
    rd_byte = 8'h00;
    if (on_slot(wb_adr_i))
    begin
      case (slot_of(wb_adr_i))
        slot_of(`LIP_OFF_PORT_B_DATA): rd_byte = pb_rd;
        slot_of(`LIP_OFF_PORT_A_DATA): rd_byte = pa_view;
        slot_of(`LIP_OFF_PORT_B_DIR): rd_byte = pb_dir_q;
        slot_of(`LIP_OFF_PORT_A_DIR): rd_byte = pa_dir_q;
        slot_of(`LIP_OFF_PORT_A_ALIAS): rd_byte = pa_view;
        // Timer, shifter, setup and interrupt slots are inert
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Sequencer: take request, wait one internal period, acknowledge
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      LIP_ST_IDLE:
      begin
        // New request starts the period delay
        if (req)
        begin
          state_d = LIP_ST_WAIT;
        end
      end
      LIP_ST_WAIT:
      begin
        // Complete only when the full period has passed
        if (tick_done)
        begin
          state_d = LIP_ST_ACK;
        end
      end
      LIP_ST_ACK:
      begin
        // Master releases the request at this edge
        state_d = LIP_ST_IDLE;
      end
      default:
      begin
        state_d = LIP_ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= LIP_ST_IDLE;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
    end
  end

  // Acknowledge and read data, one cycle per access
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_q <= commit;
      if (commit && !wb_we_i)
      begin
        rdat_q <= {24'h00_0000, rd_byte};
      end
      else
      begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  // Port A latch, reached from its own slot and the alias slot
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa_data_q <= `LIP_DATA_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && (hits(wb_adr_i, `LIP_OFF_PORT_A_DATA) ||
                    hits(wb_adr_i, `LIP_OFF_PORT_A_ALIAS)))
      begin
        pa_data_q <= wb_dat_i[7:0];
      end
    end
  end

  // Port B latch
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pb_data_q <= `LIP_DATA_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && hits(wb_adr_i, `LIP_OFF_PORT_B_DATA))
      begin
        pb_data_q <= wb_dat_i[7:0];
      end
    end
  end

  // Direction registers, cleared to inputs at reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa_dir_q <= `LIP_DIR_RST;
      pb_dir_q <= `LIP_DIR_RST;
    end
    else if (ce_i)
    begin
      if (wr_en && hits(wb_adr_i, `LIP_OFF_PORT_A_DIR))
      begin
        pa_dir_q <= wb_dat_i[7:0];
      end
      if (wr_en && hits(wb_adr_i, `LIP_OFF_PORT_B_DIR))
      begin
        pb_dir_q <= wb_dat_i[7:0];
      end
    end
  end

  // Control lines follow the driven port A bits
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clk_sel_q <= 1'b0;
      gate_a_q <= 1'b0;
      gate_b_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // One routes the external serial clock, zero the fixed clock
      clk_sel_q <= drives_one(pa_data_q, pa_dir_q, `LIP_PA_CLK_SEL_BIT);
      gate_a_q <= drives_one(pa_data_q, pa_dir_q, `LIP_PA_WAIT_A_BIT);
      gate_b_q <= drives_one(pa_data_q, pa_dir_q, `LIP_PA_WAIT_B_BIT);
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign port_a_out_o = pa_data_q;
  assign port_a_oe_o = pa_dir_q;
  assign port_b_out_o = pb_data_q;
  assign port_b_oe_o = pb_dir_q;
  assign chan_a_rxtx_clock_pin_ext_o = clk_sel_q;
  assign chan_a_wait_gate_o = gate_a_q;
  assign chan_b_wait_gate_o = gate_b_q;

endmodule // lip_top
`default_nettype wire

/* File: verification/lip_top_sva.sv */
// Checker for the port adapter: bus timing, control outputs, reset state.
// Assumes binding to lip_top with ce_i driven by the bench.
`timescale 1ns/10ps
`default_nettype none
module lip_top_sva #(
  parameter int TICK_CYC = 160
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [12:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] port_a_out_o,
  input wire logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_oe_o,
  input wire logic chan_a_rxtx_clock_pin_ext_o,
  input wire logic chan_a_wait_gate_o,
  input wire logic chan_b_wait_gate_o
);
  int unsigned wait_q; // Edges an open request has waited
  logic wr_q; // Qualified byte write
  assign wr_q = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Count edges of an open request until it is answered
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      wait_q <= 0;
    else if (!(wb_cyc_i && wb_stb_i) || wb_ack_o)
      wait_q <= 0;
    else if (ce_i)
      wait_q <= wait_q + 1;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_lat;
    wb_ack_o |-> wait_q == TICK_CYC + 2;
  endproperty
  a_lat: assert property (p_lat) else $error("ack latency wrong");
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_upper;
    wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rst;
    $rose(rst_n_i) |-> port_a_oe_o == 8'h00 && port_b_oe_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pins drive after reset");
  property p_clk;
    chan_a_rxtx_clock_pin_ext_o == $past(port_a_out_o[3] & port_a_oe_o[3]);
  endproperty
  a_clk: assert property (p_clk) else $error("clock select wrong");
  property p_gate_a;
    chan_a_wait_gate_o == $past(port_a_out_o[4] & port_a_oe_o[4]);
  endproperty
  a_gate_a: assert property (p_gate_a) else $error("gate a wrong");
  property p_gate_b;
    chan_b_wait_gate_o == $past(port_a_out_o[6] & port_a_oe_o[6]);
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("gate b wrong");
  property p_dir;
    wr_q && wb_adr_i == 13'h0600 |=> port_a_oe_o == $past(wb_dat_i[7:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_alias;
    wr_q && (wb_adr_i == 13'h0200 || wb_adr_i == 13'h1e00)
      |=> port_a_out_o == $past(wb_dat_i[7:0]);
  endproperty
  a_alias: assert property (p_alias) else $error("port a latch wrong");
  c_alias: cover property (wr_q && wb_adr_i == 13'h1e00);
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_gates: cover property (chan_a_wait_gate_o && chan_b_wait_gate_o);
endmodule // lip_top_sva
`default_nettype wire

/* File: verification/lip_serial_model.sv */
// Far-side model of the serial controller's wait/request outputs.
// Assumes the bench sets the wanted request levels after clock edges.
`timescale 1ns/10ps
`default_nettype none
module lip_serial_model (
  input wire logic mclk_i,
  input wire logic req_a_i,
  input wire logic req_b_i,
  output logic wait_a_n_o,
  output logic wait_b_n_o
);
  // Lines are active low; a request shows one edge later
  always_ff @(posedge mclk_i)
  begin
    wait_a_n_o <= ~req_a_i;
    wait_b_n_o <= ~req_b_i;
  end
endmodule // lip_serial_model
`default_nettype wire

/* File: verification/legacy_io_port_adapter_tb_top.sv */
// Bench for the port adapter: bus tasks, pin and wait stimulus, checks.
// Assumes lip_top, lip_serial_model and lip_top_sva are compiled first.
`timescale 1ns/10ps
`default_nettype none
module legacy_io_port_adapter_tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1; // Clock enable, on except for five cycles in the stretch test
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [12:0] wb_adr_i = 13'h0000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] pa_ext = 8'h00; // Peripheral drive on port A
  logic [7:0] pb_ext = 8'h00; // Peripheral drive on port B
  logic req_a = 1'b0; // Channel A wait requested
  logic req_b = 1'b0; // Channel B wait requested
  logic [7:0] port_a_out_o, port_a_oe_o, port_b_out_o, port_b_oe_o;
  logic gate_a, gate_b, clk_ext, wait_a_n, wait_b_n;
  logic [31:0] seed = 32'h00000038; // Random state
  logic [7:0] da, ra, db, rb, rd;
  logic [3:0] sel_v = 4'hf; // Byte enables for the next access
  int n_mismatch = 0;
  int compares = 0;
  // Pin level: our driver where enabled, else the peripheral
  wire logic [7:0] pa_pin = (port_a_oe_o & port_a_out_o) | (~port_a_oe_o & pa_ext);
  wire logic [7:0] pb_pin = (port_b_oe_o & port_b_out_o) | (~port_b_oe_o & pb_ext);
  always #4 mclk_i = ~mclk_i;
  lip_serial_model u_model (.mclk_i(mclk_i), .req_a_i(req_a), .req_b_i(req_b),
    .wait_a_n_o(wait_a_n), .wait_b_n_o(wait_b_n));
  lip_top #(.TICK_CYC(4)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_a_in_i(pa_pin),
    .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
    .port_b_in_i(pb_pin), .port_b_out_o(port_b_out_o), .port_b_oe_o(port_b_oe_o),
    .chan_a_wait_request_n_i(wait_a_n), .chan_b_wait_request_n_i(wait_b_n),
    .chan_a_rxtx_clock_pin_ext_o(clk_ext), .chan_a_wait_gate_o(gate_a),
    .chan_b_wait_gate_o(gate_b));
  // Xorshift step, one byte out
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Port A read-back from latch, direction, pins and gated waits
  function automatic logic [7:0] exp_a(input logic [7:0] d, input logic [7:0] r);
    logic w;
    w = ((d[4] & r[4]) ? ~req_a : 1'b1) & ((d[6] & r[6]) ? ~req_b : 1'b1);
    return (d & r) | (((pa_ext & 8'h58) | {w, 7'h00}) & ~r);
  endfunction
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("mismatch %0t got %h want %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // One classic cycle; held until ack is sampled
  task automatic bus(input logic we, input logic [12:0] adr, input logic [7:0] wd);
    int n;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 64)
    begin
      $display("mismatch %0t bus timeout", $time);
      n_mismatch++;
      wrap_up();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 13'h0600, 8'h00);
    chk(rd, 8'h00);
    bus(1'b0, 13'h0400, 8'h00);
    chk(rd, 8'h00);
    // Directed gate and wait combinations first, random after
    for (int i = 0; i < 40; i++)
    begin
      da = (i < 16) ? {1'b0, i[1], 1'b0, i[0], i[0], 3'h0} : rnd();
      ra = (i < 16) ? 8'h58 : rnd();
      db = rnd();
      rb = rnd();
      pa_ext <= rnd();
      pb_ext <= rnd();
      req_a <= i[2];
      req_b <= i[3];
      bus(1'b1, i[0] ? 13'h1e00 : 13'h0200, da);
      bus(1'b1, 13'h0600, ra);
      bus(1'b1, 13'h0000, db);
      bus(1'b1, 13'h0400, rb);
      bus(1'b0, 13'h0200, 8'h00);
      chk(rd, exp_a(da, ra));
      bus(1'b0, 13'h1e00, 8'h00);
      chk(rd, exp_a(da, ra));
      bus(1'b0, 13'h0000, 8'h00);
      chk(rd, db & rb);
      bus(1'b0, 13'h0400, 8'h00);
      chk(rd, rb);
      chk(port_b_oe_o, rb);
      chk(port_b_out_o, db);
      chk(port_a_out_o, da);
      chk(port_a_oe_o, ra);
      chk({5'h00, gate_b, gate_a, clk_ext}, {5'h00, da[6] & ra[6], da[4] & ra[4], da[3] & ra[3]});
    end
    // Clock enable low in mid-access stretches the wait
    fork
      bus(1'b0, 13'h0400, 8'h00);
      begin
        repeat (3) @(posedge mclk_i);
        ce_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        ce_i <= 1'b1;
      end
    join
    chk(rd, rb);
    // Write with the low byte lane off is dropped
    sel_v = 4'he;
    bus(1'b1, 13'h0400, ~rb);
    sel_v = 4'hf;
    bus(1'b0, 13'h0400, 8'h00);
    chk(rd, rb);
    // Timer, shifter, setup and flag slots: dropped and read as zero
    for (int s = 4; s < 15; s++)
    begin
      bus(1'b1, 13'(s << 9), rnd());
      bus(1'b0, 13'(s << 9), 8'h00);
      chk(rd, 8'h00);
    end
    bus(1'b0, 13'h0201, 8'h00);
    chk(rd, 8'h00);
    // Mid-run reset returns both ports to inputs
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    chk(port_a_oe_o, 8'h00);
    chk(port_b_oe_o, 8'h00);
    chk({5'h00, gate_b, gate_a, clk_ext}, 8'h00);
    bus(1'b0, 13'h0600, 8'h00);
    chk(rd, 8'h00);
    wrap_up();
  end
endmodule // legacy_io_port_adapter_tb_top
bind lip_top lip_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (.mclk_i, .rst_n_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .port_a_out_o, .port_a_oe_o, .port_b_oe_o,
  .chan_a_rxtx_clock_pin_ext_o, .chan_a_wait_gate_o, .chan_b_wait_gate_o);
`default_nettype wire
